/* File: rtl/scp_pkg.sv */
// Purpose: constants and carrier types for the six-bit port with change detect
// Assumes: 8-bit register port, registers at word indices chosen locally
// Notes: bits 7:6 of every register read as zero
package scp_pkg;
   localparam int PIN_COUNT = 6;
   localparam logic [2:0] ADDR_PORT_PIN_DATA = 3'h0;
   localparam logic [2:0] ADDR_PORT_DIRECTION = 3'h1;
   localparam logic [2:0] ADDR_PULL_POLARITY = 3'h2;
   localparam logic [2:0] ADDR_PULL_ENABLE = 3'h3;
   localparam logic [2:0] ADDR_CHANGE_ENABLE = 3'h4;
   localparam logic [2:0] ADDR_CONTROL = 3'h5;
   localparam logic [2:0] ADDR_STATUS = 3'h6;
   // control register fields
   localparam int CTL_GLOBAL_PULL_DISABLE = 0;
   localparam int CTL_FLAG_CLEAR = 1;
   // status register fields
   localparam int STS_CHANGE_FLAG = 0;
   localparam int STS_WAKE = 1;
   // pin positions
   localparam int PIN_INPUT_ONLY = 3;
   localparam int PIN_OSC_OUT = 4;
   localparam int PIN_OSC_IN = 5;
   localparam logic [5:0] RST_DIRECTION = 6'h3f;
   localparam logic [5:0] RST_PULL_POLARITY = 6'h37;
   localparam logic [5:0] RST_PULL_ENABLE = 6'h37;
   localparam logic [5:0] RST_CHANGE_ENABLE = 6'h00;
   localparam logic [5:0] IMPL_PULL_MASK = 6'h37;
   localparam logic [5:0] OSC_PIN_MASK = 6'h30;
   localparam logic [5:0] ALL_ONES6 = 6'h3f;
   localparam logic [5:0] ZERO6 = 6'h00;
   localparam logic [1:0] ZERO2 = 2'h0;
   localparam logic [7:0] ZERO8 = 8'h00;

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } scp_bus_req_type;

   typedef struct packed {
      logic crystalMode;        // crystal, high-speed or low-power crystal
      logic intOscEnabled;
      logic timerOscEnabled;
      logic oscOutPin;
      logic masterClearPinEnable;
      logic programmingVoltage;
      logic sleeping;
      logic [5:0] analogMask;
      logic [5:0] altFuncMask;
      logic powerOnReset;
   } scp_cfg_type;

   typedef struct packed {
      logic [5:0] pinOut;
      logic [5:0] pinOe_n;
      logic [5:0] pullUpOn;
      logic [5:0] pullDownOn;
   } scp_pad_type;
endpackage : scp_pkg

/* File: rtl/scp_port.sv */
// Purpose: six-bit bidirectional port with pulls and change detection
// Assumes: pins asynchronous to core_clk; srst is master clear or brown-out
// Notes: cfg.powerOnReset additionally clears the change latch and change flag
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps

// Functional notes
// - six pins in bits 5:0; bits 7:6 of registers read zero
// - direction bit one tri-states the pin driver
// - direction bit zero drives the pin from the output latch
// - pin 3 input only; direction reads one, port bit read-only
// - port read returns pin levels; write updates the output latch
// - port write loads write data into the latch; only bit 3 takes the pin level
// - pin 3 reads zero when master clear pin is enabled
// - analog pins read zero; direction bits still control them
// - crystal modes force direction bits 5:4 to read one
// - polarity bit one selects pull-up, zero pull-down; no pin 3
// - pull active only if global enable, input, enabled, not analog/clock
// - pulls off for outputs, alternate functions, power-on, global disable
// - pin 3 pull-up on as master clear unless programming voltage
// - pull enable bits 5 and 4 write-guarded, read one when locked
// - per-pin change enable, cleared on power-on reset
// - enabled pin mismatches against read latch OR into change flag
// - change flag can wake the device from sleep
// - port access reloads compare latch, ending the mismatch
// - compare latch survives master clear and brown-out reset
// - change coinciding with a port read may be missed
// - change enable bits 5:0, one enables detection
// - change enable bits 5:4 read zero in crystal modes
module scp_port (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // register port
   input wire scp_pkg::scp_bus_req_type busReq,
   output logic [7:0] rdData,
   // configuration
   input wire scp_pkg::scp_cfg_type cfg,
   // pins
   input wire logic [5:0] pinIn,
   output scp_pkg::scp_pad_type pad,
   // events
   output logic portChangeFlag,
   output logic wakeRequest
);
   import scp_pkg::*;

   typedef struct packed {
      logic [5:0] sync1;
      logic [5:0] sync2;
      logic [5:0] sync3;
      logic [5:0] pinLevel;
      logic [5:0] outLatch;
      logic [5:0] direction;
      logic [5:0] pullPolarity;
      logic [5:0] pullEnable;
      logic [5:0] changeEnable;
      logic [5:0] compareLatch;
      logic globalPullDisable;
      logic changeFlag;
      logic wake;
      logic [7:0] rdData;
      scp_pad_type pad;
   } scp_state_type;

   scp_state_type state_reg, state_next;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [5:0] readPins(input logic [5:0] lvl, input scp_cfg_type c);
      logic [5:0] v;
      v = lvl & ~c.analogMask;
      if (c.masterClearPinEnable) begin
         v[PIN_INPUT_ONLY] = 1'b0;
      end
      return v;
   endfunction : readPins

   function automatic logic [5:0] readDirection(input logic [5:0] d, input scp_cfg_type c);
      logic [5:0] v;
      v = d;
      v[PIN_INPUT_ONLY] = 1'b1;
      if (c.crystalMode) begin
         v = v | OSC_PIN_MASK;
      end
      return v;
   endfunction : readDirection

   function automatic logic [5:0] pullLock(input scp_cfg_type c);
      logic [5:0] v;
      v = ZERO6;
      v[PIN_OSC_IN] = !(c.intOscEnabled && !c.timerOscEnabled);
      v[PIN_OSC_OUT] = c.oscOutPin;
      return v;
   endfunction : pullLock

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      logic [5:0] pins;
      logic [5:0] dirEff;
      logic [5:0] lock;
      logic [5:0] pullOn;
      logic [5:0] mismatch;
      logic [5:0] merged;
      logic portAccess;
      pins = ZERO6;
      dirEff = ZERO6;
      lock = ZERO6;
      pullOn = ZERO6;
      mismatch = ZERO6;
      merged = ZERO6;
      portAccess = 1'b0;
      state_next = state_reg;

      // first stage feeds only the second; change counted when 2 and 3 agree
      state_next.sync1 = pinIn;
      state_next.sync2 = state_reg.sync1;
      state_next.sync3 = state_reg.sync2;
      for (int i = 0; i < PIN_COUNT; i++) begin
         if (state_reg.sync2[i] == state_reg.sync3[i]) begin
            state_next.pinLevel[i] = state_reg.sync3[i];
         end
      end

      pins = readPins(state_reg.pinLevel, cfg);
      dirEff = readDirection(state_reg.direction, cfg);
      lock = pullLock(cfg);
      portAccess = (busReq.rd || busReq.wr) && busReq.addr == ADDR_PORT_PIN_DATA;

      // register writes
      if (busReq.wr) begin
         case (busReq.addr)
            ADDR_PORT_PIN_DATA: begin
               // bit-level update of the pin image; pin 3 stays read-only
               merged = busReq.wdata[5:0];
               merged[PIN_INPUT_ONLY] = pins[PIN_INPUT_ONLY];
               state_next.outLatch = merged;
            end
            ADDR_PORT_DIRECTION: begin
               state_next.direction = busReq.wdata[5:0];
               state_next.direction[PIN_INPUT_ONLY] = 1'b1;
            end
            ADDR_PULL_POLARITY: begin
               state_next.pullPolarity = busReq.wdata[5:0] & IMPL_PULL_MASK;
            end
            ADDR_PULL_ENABLE: begin
               state_next.pullEnable = ((busReq.wdata[5:0] & ~lock) | (state_reg.pullEnable & lock))
                                       & IMPL_PULL_MASK;
            end
            ADDR_CHANGE_ENABLE: begin
               state_next.changeEnable = busReq.wdata[5:0];
            end
            ADDR_CONTROL: begin
               state_next.globalPullDisable = busReq.wdata[CTL_GLOBAL_PULL_DISABLE];
            end
            default: begin
            end
         endcase
      end

      // change detection; an access reloads the latch so the mismatch ends
      if (portAccess) begin
         state_next.compareLatch = pins;
      end
      // a change landing in the access cycle is absorbed by the reload
      mismatch = (pins ^ state_reg.compareLatch) & state_reg.changeEnable;
      if (cfg.crystalMode) begin
         mismatch = mismatch & ~OSC_PIN_MASK;
      end
      if (busReq.wr && busReq.addr == ADDR_CONTROL && busReq.wdata[CTL_FLAG_CLEAR]) begin
         state_next.changeFlag = 1'b0;
      end
      if (|mismatch && !portAccess) begin
         state_next.changeFlag = 1'b1;
      end
      state_next.wake = state_next.changeFlag && cfg.sleeping;

      // read data, one cycle after the strobe
      state_next.rdData = ZERO8;
      if (busReq.rd) begin
         case (busReq.addr)
            ADDR_PORT_PIN_DATA: state_next.rdData = {ZERO2, pins};
            ADDR_PORT_DIRECTION: state_next.rdData = {ZERO2, dirEff};
            ADDR_PULL_POLARITY: state_next.rdData = {ZERO2, state_reg.pullPolarity};
            ADDR_PULL_ENABLE: state_next.rdData = {ZERO2, (state_reg.pullEnable | lock) & IMPL_PULL_MASK};
            ADDR_CHANGE_ENABLE: begin
               state_next.rdData = {ZERO2, state_reg.changeEnable};
               if (cfg.crystalMode) begin
                  state_next.rdData[5:4] = ZERO2;
               end
            end
            ADDR_CONTROL: state_next.rdData = {7'h00, state_reg.globalPullDisable};
            ADDR_STATUS: state_next.rdData = {6'h00, state_reg.wake, state_reg.changeFlag};
            default: state_next.rdData = ZERO8;
         endcase
      end

      // pad drive and weak pulls
      state_next.pad.pinOut = state_next.outLatch;
      state_next.pad.pinOe_n = dirEff;
      // polarity picks up or down below; gating on it here would make pull-downs unreachable
      pullOn = ~state_next.globalPullDisable ? (dirEff & state_next.pullEnable
               & ~cfg.analogMask & ~cfg.altFuncMask & IMPL_PULL_MASK) : ZERO6;
      if (cfg.crystalMode) begin
         pullOn = pullOn & ~OSC_PIN_MASK;
      end
      state_next.pad.pullUpOn = pullOn & state_next.pullPolarity;
      state_next.pad.pullDownOn = pullOn & ~state_next.pullPolarity;
      state_next.pad.pullUpOn[PIN_INPUT_ONLY] = cfg.masterClearPinEnable && !cfg.programmingVoltage;
      state_next.pad.pullDownOn[PIN_INPUT_ONLY] = 1'b0;

      if (cfg.powerOnReset) begin
         state_next.changeEnable = RST_CHANGE_ENABLE;
         state_next.globalPullDisable = 1'b1;
         state_next.compareLatch = ZERO6;
         state_next.changeFlag = 1'b0;
         state_next.pad.pullUpOn = ZERO6;
         state_next.pad.pullDownOn = ZERO6;
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_reg <= state_next;
         // the compare latch, sync chain and change flag are kept across this reset
         state_reg.outLatch <= ZERO6;
         state_reg.direction <= RST_DIRECTION;
         state_reg.pullPolarity <= RST_PULL_POLARITY;
         state_reg.pullEnable <= RST_PULL_ENABLE;
         state_reg.changeEnable <= RST_CHANGE_ENABLE;
         state_reg.globalPullDisable <= 1'b1;
         state_reg.wake <= 1'b0;
         state_reg.rdData <= ZERO8;
         state_reg.pad <= '{pinOut: ZERO6, pinOe_n: ALL_ONES6, pullUpOn: ZERO6, pullDownOn: ZERO6};
         state_reg.compareLatch <= state_next.compareLatch;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rdData = state_reg.rdData;
   assign pad = state_reg.pad;
   assign portChangeFlag = state_reg.changeFlag;
   assign wakeRequest = state_reg.wake;
endmodule : scp_port

/* File: tb/scp_pin_model.sv */
// Purpose: pins and outside drivers facing scp_port
// Assumes: outside drivers hold every pin not driven by the port
// Notes: weak pulls lose against a strong outside driver
`timescale 1ns/1ps
module scp_pin_model (
   // device side
   input wire scp_pkg::scp_pad_type pad,
   // far side
   input wire logic [5:0] extLevel,
   output logic [5:0] pinIn
);
   import scp_pkg::*;
   assign pinIn = (pad.pinOut & ~pad.pinOe_n) | (extLevel & pad.pinOe_n);
endmodule : scp_pin_model

/* File: tb/scp_port_asserts.sv */
// Purpose: port-level checks for scp_port
// Assumes: cfg held steady around register reads
// Notes: bound onto every scp_port instance
`timescale 1ns/1ps
module scp_port_asserts (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // register port
   input wire scp_pkg::scp_bus_req_type busReq,
   input wire logic [7:0] rdData,
   // configuration and pins
   input wire scp_pkg::scp_cfg_type cfg,
   input wire logic [5:0] pinIn,
   input wire scp_pkg::scp_pad_type pad,
   // events
   input wire logic portChangeFlag,
   input wire logic wakeRequest
);
   import scp_pkg::*;
   // ---
   // checks
   // ---
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   sequence s_rd(a);
      busReq.rd && busReq.addr == a;
   endsequence
   a_rd_idle_zero: assert property (!busReq.rd |=> rdData == 8'h00) else $error("read data not idle");
   a_hi_bits_zero: assert property (rdData[7:6] == 2'h0) else $error("upper read bits set");
   a_pin3_input: assert property (pad.pinOe_n[3] && !pad.pullDownOn[3]) else $error("pin 3 driven");
   a_dir_read: assert property (s_rd(ADDR_PORT_DIRECTION) |=> rdData[3] &&
      (!$past(cfg.crystalMode) || rdData[5:4] == 2'h3)) else $error("direction read wrong");
   a_chg_xtal: assert property (s_rd(ADDR_CHANGE_ENABLE) ##0 cfg.crystalMode |=> rdData[5:4] == 2'h0)
      else $error("change enable 5:4 not zero");
   a_pen_lock: assert property (s_rd(ADDR_PULL_ENABLE) ##0 !cfg.intOscEnabled |=> rdData[5])
      else $error("locked pull enable reads zero");
   a_master_clear_input_read: assert property (s_rd(ADDR_PORT_PIN_DATA) ##0 cfg.masterClearPinEnable |=> !rdData[3])
      else $error("pin 3 not zero");
   a_pull_excl: assert property ((pad.pullUpOn & pad.pullDownOn) == 6'h00) else $error("both pulls on");
   a_pull_gdis: assert property (busReq.wr && busReq.addr == ADDR_CONTROL && busReq.wdata[0] |->
      ##[1:3] ((pad.pullUpOn & 6'h37) | pad.pullDownOn) == 6'h00) else $error("pulls still on");
   a_flag_clear: assert property ($fell(portChangeFlag) |-> $past(cfg.powerOnReset ||
      busReq.wr && busReq.addr == ADDR_CONTROL && busReq.wdata[1])) else $error("flag dropped");
   a_no_set_acc: assert property ($rose(portChangeFlag) |->
      !$past(busReq.addr == ADDR_PORT_PIN_DATA && (busReq.rd || busReq.wr))) else $error("flag set on access");
   a_wake_flag: assert property (cfg.sleeping ##1 portChangeFlag |-> wakeRequest)
      else $error("no wake request");
endmodule : scp_port_asserts

bind scp_port scp_port_asserts scp_port_asserts_i (.core_clk(core_clk), .srst(srst), .busReq(busReq),
   .rdData(rdData), .cfg(cfg), .pinIn(pinIn), .pad(pad), .portChangeFlag(portChangeFlag),
   .wakeRequest(wakeRequest));

/* File: tb/tb_top.sv */
// Purpose: self-checking bench for scp_port
// Assumes: cfg changes only while the bus is idle
// Notes: reads queue their expectation; a monitor compares
`timescale 1ns/1ps
module tb_top;
   import scp_pkg::*;
   // ---
   // signals
   // ---
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   scp_bus_req_type busReq = '0;
   scp_cfg_type cfg = '0;
   logic [7:0] rdData;
   logic [5:0] pinIn;
   logic [5:0] extLevel = 6'h00;
   scp_pad_type pad;
   logic portChangeFlag;
   logic wakeRequest;
   logic rdLast = 1'b0;
   logic [7:0] expQ[$];
   logic [7:0] mskQ[$];
   logic [10:0] rstTab[5] = '{{3'h1, 8'h3f}, {3'h2, 8'h37}, {3'h3, 8'h37}, {3'h4, 8'h00}, {3'h7, 8'h00}};
   logic [7:0] e;
   int nErrors = 0;
   int testsRun = 0;
   int i;
   always #5 core_clk = ~core_clk;
   scp_port scp_port_i (.core_clk(core_clk), .srst(srst), .busReq(busReq), .rdData(rdData), .cfg(cfg),
      .pinIn(pinIn), .pad(pad), .portChangeFlag(portChangeFlag), .wakeRequest(wakeRequest));
   scp_pin_model scp_pin_model_i (.pad(pad), .extLevel(extLevel), .pinIn(pinIn));
   // ---
   // tasks
   // ---
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      testsRun++;
      if (seen !== exp) begin
         nErrors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task stop_test;
      $display("errors %0d checks %0d", nErrors, testsRun);
      if (nErrors == 0 && testsRun > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : stop_test
   // a gap cycle after each strobe keeps a release and a new request out of one time step
   task automatic bus(input logic [2:0] a, input logic [7:0] d, input logic w);
      busReq <= '{a, d, w, !w};
      @(posedge core_clk);
      busReq <= '0;
      @(posedge core_clk);
   endtask : bus
   task automatic rd(input logic [2:0] a, input logic [7:0] x, input logic [7:0] m);
      expQ.push_back(x & m);
      mskQ.push_back(m);
      bus(a, 8'h00, 1'b0);
   endtask : rd
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask : tick
   task automatic flag(input logic x);
      chk({7'h0, portChangeFlag}, {7'h0, x});
   endtask : flag
   always @(posedge core_clk) begin
      if (rdLast)
         chk(rdData & mskQ.pop_front(), expQ.pop_front());
      rdLast <= busReq.rd;
   end
   initial begin
      #20000;
      nErrors++;
      stop_test;
   end
   // ---
   // scenarios
   // ---
   initial begin
      void'($urandom(13));
      cfg.powerOnReset = 1'b1;
      cfg.intOscEnabled = 1'b1;
      tick(8);
      srst <= 1'b0;
      cfg.powerOnReset <= 1'b0;
      foreach (rstTab[k]) rd(rstTab[k][10:8], rstTab[k][7:0], 8'hff);
      bus(ADDR_PORT_DIRECTION, 8'hff, 1'b1);
      rd(ADDR_PORT_DIRECTION, 8'h3f, 8'hff);
      bus(ADDR_PORT_DIRECTION, 8'h00, 1'b1);
      rd(ADDR_PORT_DIRECTION, 8'h08, 8'hff);
      e = 8'($urandom);
      extLevel <= 6'($urandom);
      bus(ADDR_PORT_PIN_DATA, e, 1'b1);
      tick(8);
      chk({2'h0, pad.pinOe_n}, 8'h08);
      chk({2'h0, pad.pinOut & 6'h37}, {2'h0, e[5:0] & 6'h37});
      rd(ADDR_PORT_PIN_DATA, {2'h0, e[5:4], extLevel[3], e[2:0]}, 8'hff);
      // inputs, analog pins and master clear on pin 3
      bus(ADDR_PORT_DIRECTION, 8'h3f, 1'b1);
      e = 8'($urandom);
      extLevel <= e[5:0];
      cfg.analogMask <= 6'h03;
      cfg.masterClearPinEnable <= 1'b1;
      tick(8);
      rd(ADDR_PORT_PIN_DATA, {2'h0, e[5:4], 1'b0, e[2], 2'h0}, 8'hff);
      chk({7'h0, pad.pullUpOn[3]}, 8'h01);
      cfg.programmingVoltage <= 1'b1;
      tick(3);
      chk({7'h0, pad.pullUpOn[3]}, 8'h00);
      cfg <= '{intOscEnabled: 1'b1, default: '0};
      // weak pulls
      bus(ADDR_CONTROL, 8'h00, 1'b1);
      bus(ADDR_PULL_POLARITY, 8'h05, 1'b1);
      tick(3);
      chk({2'h0, pad.pullUpOn}, 8'h05);
      chk({2'h0, pad.pullDownOn}, 8'h32);
      bus(ADDR_PORT_DIRECTION, 8'h3e, 1'b1);
      tick(3);
      chk({2'h0, pad.pullUpOn}, 8'h04);
      bus(ADDR_CONTROL, 8'h01, 1'b1);
      tick(3);
      chk({2'h0, pad.pullUpOn | pad.pullDownOn}, 8'h00);
      // change detection, wake and reset survival
      bus(ADDR_PORT_DIRECTION, 8'h3f, 1'b1);
      bus(ADDR_CHANGE_ENABLE, 8'h07, 1'b1);
      rd(ADDR_PORT_PIN_DATA, {2'h0, e[5:0]}, 8'hff);
      bus(ADDR_CONTROL, 8'h03, 1'b1);
      tick(2);
      flag(1'b0);
      extLevel <= e[5:0] ^ 6'h02;
      cfg.sleeping <= 1'b1;
      for (i = 0; i < 12 && portChangeFlag !== 1'b1; i++) @(posedge core_clk);
      flag(1'b1);
      tick(2);
      chk({7'h0, wakeRequest}, 8'h01);
      cfg.sleeping <= 1'b0;
      bus(ADDR_CONTROL, 8'h03, 1'b1);
      tick(2);
      flag(1'b1);
      srst <= 1'b1;
      tick(1);
      srst <= 1'b0;
      tick(2);
      flag(1'b1);
      bus(ADDR_CHANGE_ENABLE, 8'h07, 1'b1);
      rd(ADDR_PORT_PIN_DATA, {2'h0, e[5:0] ^ 6'h02}, 8'hff);
      bus(ADDR_CONTROL, 8'h03, 1'b1);
      extLevel <= e[5:0] ^ 6'h12;
      tick(12);
      flag(1'b0);
      cfg.powerOnReset <= 1'b1;
      tick(2);
      cfg.powerOnReset <= 1'b0;
      rd(ADDR_CHANGE_ENABLE, 8'h00, 8'hff);
      // crystal mode and locked pull enable
      cfg.crystalMode <= 1'b1;
      cfg.intOscEnabled <= 1'b0;
      bus(ADDR_PORT_DIRECTION, 8'h00, 1'b1);
      rd(ADDR_PORT_DIRECTION, 8'h38, 8'hff);
      bus(ADDR_CHANGE_ENABLE, 8'h3f, 1'b1);
      rd(ADDR_CHANGE_ENABLE, 8'h0f, 8'hff);
      bus(ADDR_PULL_ENABLE, 8'h00, 1'b1);
      rd(ADDR_PULL_ENABLE, 8'h20, 8'h20);
      // let the monitor take the last read before closing
      tick(1);
      stop_test;
   end
endmodule : tb_top
